// *** twi_slave_match.sv ***
// Notes on behaviour
// - each received address is compared with the own address, qualified by the mask register, and a match sets the address-or-stop flag.
// - 7-bit addresses, the first byte of 10-bit addresses and general call are recognised.
// - own address bits 7:1 are the slave address and bit 0 enables general call.
// - for 10-bit addressing only the first byte 11110 plus bits 9:8 is matched, software checks the second.
// - the slave byte register is the one shift register used for both transmit and receive.
// - writes to the slave byte register are ignored while a byte is shifting.
// - byte register access is valid only while the slave stretches the clock.
// - a byte register access while stretching, except a read while transmitting, launches the next bus step, chosen by acknowledge action and access type.
// - mask register bit 0 is the dual-address select and bits 7:1 the seven-bit field.
// - with select at 0 a mask bit of one makes that address bit always match.
// - with select at 1 either the own address or the seven-bit field matches.
// - the address-or-stop flag is set on an address match or on a Stop.
// - the cause bit reads 1 for an address and 0 for a Stop.
// - the clock-stretch flag is set with the data flag or an address match (not on a Stop) and clears with it.
// - the data-complete flag clears on a byte register access or a valid command write.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module twi_slave_match (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import twi_pkg::*;

  // ----------------------------------------
  // address match
  // ----------------------------------------
  function automatic logic addr_match(input logic [6:0] rx,
      input logic [7:0] own, input logic [7:0] msk);
    logic gc;
    gc = own[0] && (rx == 7'h00);
    if (msk[0]) begin
      addr_match = gc || rx == own[7:1] || rx == msk[7:1];
    end else begin
      addr_match = gc || ((rx ^ own[7:1]) & ~msk[7:1]) == 7'h00;
    end
  endfunction : addr_match

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] scl_s, sda_s;
  logic scl_d, sda_d;
  always_ff @(posedge clk) begin
    if (rst) begin
      {scl_s, sda_s, scl_d, sda_d} <= 6'h3f;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      {scl_d, sda_d} <= {scl_s[1], sda_s[1]};
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s[1] && !scl_d;
  assign scl_fall = !scl_s[1] && scl_d;
  assign start_c = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign stop_c = scl_s[1] && scl_d && !sda_d && sda_s[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  twi_state_t st, next_st;
  ack_next_t ack_nx, next_ack_nx;
  logic [7:0] shift, next_shift;
  logic [3:0] bitcnt, next_bitcnt;
  logic data_complete_flag, next_dif, address_or_stop_flag, next_address_or_stop_flag, cause, next_cause;
  logic dir, next_dir, rxack, next_rxack;
  logic [7:0] own, next_own, msk, next_msk, imask, next_imask;
  logic acknowledge_action, next_acknowledge_action, waitreq, next_waitreq;
  logic [31:0] rdata, next_rdata;
  logic next_irq, next_scl_oe, next_sda_oe;
  logic wr_go, rd_go, wr_data, rd_data, cmd_ok, dif_set, address_or_stop_flag_set;
  logic [5:0] idx;
  logic [7:0] status;

  assign idx = avs_address[7:2];
  // accesses take effect at the edge where waitrequest is seen low
  assign wr_go = avs_write && !waitreq && avs_byteenable[0]
                 && avs_address[1:0] == 2'h0;
  assign rd_go = avs_read && !waitreq;
  assign wr_data = wr_go && idx == IDX_DATA;
  assign rd_data = rd_go && idx == IDX_DATA;
  assign cmd_ok = wr_go && idx == IDX_CTRL
                  && (avs_writedata[1:0] == CMD_COMPTRANS
                  || avs_writedata[1:0] == CMD_RESPONSE);
  assign status = {data_complete_flag, address_or_stop_flag, st == S_HOLD, rxack, 2'h0, dir, cause};

  always_comb begin
    next_st = st;
    next_ack_nx = ack_nx;
    {next_shift, next_own, next_msk, next_imask} = {shift, own, msk, imask};
    {next_bitcnt, next_dir, next_rxack, next_cause} =
        {bitcnt, dir, rxack, cause};
    {next_sda_oe, next_acknowledge_action, next_rdata} = {sda_oe, acknowledge_action, rdata};
    {next_waitreq, dif_set, address_or_stop_flag_set} = 3'b100;
    // one wait cycle, then the answer
    if ((avs_read || avs_write) && waitreq) begin
      next_waitreq = 1'b0;
      next_rdata = 32'h0;
      case (idx)
        IDX_CTRL: next_rdata[CT_ACKNOWLEDGE_ACTION] = acknowledge_action;
        IDX_STATUS: next_rdata[7:0] = status;
        IDX_OWN: next_rdata[7:0] = own;
        IDX_DATA: next_rdata[7:0] = shift;
        IDX_MASK: next_rdata[7:0] = msk;
        IDX_IRQ_MASK: next_rdata[7:0] = imask;
        default: next_rdata = 32'h0;
      endcase
    end
    if (wr_go) begin
      case (idx)
        IDX_CTRL: next_acknowledge_action = avs_writedata[CT_ACKNOWLEDGE_ACTION];
        IDX_OWN: next_own = avs_writedata[7:0];
        IDX_MASK: next_msk = avs_writedata[7:0];
        IDX_IRQ_MASK: next_imask = avs_writedata[7:0];
        default: next_imask = next_imask;
      endcase
    end
    // bus engine
    case (st)
      S_IDLE: next_sda_oe = 1'b0;
      S_ADDR, S_RX: begin
        if (scl_rise) begin
          next_shift = {shift[6:0], sda_s[1]};
          next_bitcnt = bitcnt + 4'h1;
        end else if (scl_fall && bitcnt == BITS_PER_BYTE) begin
          if (st == S_RX) begin
            dif_set = 1'b1;
            next_st = S_HOLD;
          end else if (addr_match(shift[7:1], own, msk)) begin
            address_or_stop_flag_set = 1'b1;
            next_cause = 1'b1;
            next_dir = shift[0];
            next_st = S_HOLD;
          end else begin
            next_st = S_IDLE;
          end
        end
      end
      S_HOLD: begin
        // stretching; software access picks the next step
        if (address_or_stop_flag && cause) begin
          if (cmd_ok || wr_data || rd_data) begin
            next_st = S_ACK;
            next_sda_oe = !next_acknowledge_action;
            next_ack_nx = (cmd_ok && avs_writedata[1:0] == CMD_COMPTRANS)
                          ? AN_IDLE : (dir ? AN_HOLD : AN_RX);
          end
        end else if (dir) begin
          if (wr_data) begin
            next_shift = avs_writedata[7:0];
            next_bitcnt = 4'h0;
            next_sda_oe = !avs_writedata[7];
            next_st = S_TX;
          end else if (cmd_ok && avs_writedata[1:0] == CMD_COMPTRANS) begin
            next_st = S_IDLE;
          end
        end else if (cmd_ok || rd_data || wr_data) begin
          if (wr_data) begin
            next_shift = avs_writedata[7:0];
          end
          next_st = S_ACK;
          next_sda_oe = !next_acknowledge_action;
          next_ack_nx = (cmd_ok && avs_writedata[1:0] == CMD_COMPTRANS)
                        ? AN_IDLE : AN_RX;
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          next_sda_oe = 1'b0;
          next_bitcnt = 4'h0;
          case (ack_nx)
            AN_HOLD: begin
              dif_set = 1'b1;
              next_st = S_HOLD;
            end
            AN_IDLE: next_st = S_IDLE;
            default: next_st = S_RX;
          endcase
        end
      end
      S_TX: begin
        if (scl_rise) begin
          next_bitcnt = bitcnt + 4'h1;
        end else if (scl_fall) begin
          if (bitcnt == BITS_PER_BYTE) begin
            next_sda_oe = 1'b0;
            next_st = S_RACK;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_sda_oe = !shift[6];
          end
        end
      end
      S_RACK: begin
        if (scl_rise) begin
          next_rxack = sda_s[1];
        end else if (scl_fall) begin
          dif_set = 1'b1;
          next_st = S_HOLD;
        end
      end
      default: next_st = S_IDLE;
    endcase
    if (stop_c) begin
      address_or_stop_flag_set = 1'b1;
      next_cause = 1'b0;
      next_sda_oe = 1'b0;
      next_st = S_IDLE;
    end else if (start_c) begin
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
      next_st = S_ADDR;
    end
    // flag clears lose to a set in the same cycle
    {next_dif, next_address_or_stop_flag} = {data_complete_flag, address_or_stop_flag};
    if (wr_data || rd_data || cmd_ok) begin
      {next_dif, next_address_or_stop_flag} = 2'b00;
    end
    if (wr_go && idx == IDX_STATUS) begin
      next_dif = next_dif && !avs_writedata[ST_DIF];
      next_address_or_stop_flag = next_address_or_stop_flag && !avs_writedata[ST_ADDRESS_OR_STOP_FLAG];
    end
    next_dif = next_dif || dif_set;
    next_address_or_stop_flag = next_address_or_stop_flag || address_or_stop_flag_set;
    // stretch only while a flag awaits service
    if (next_st == S_HOLD && !next_dif && !next_address_or_stop_flag) begin
      next_st = S_IDLE;
    end
    next_scl_oe = next_st == S_HOLD;
    next_irq = |({next_dif, next_address_or_stop_flag, 6'h0} & imask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= S_IDLE;
      ack_nx <= AN_RX;
      {shift, own, msk, imask} <= {4{RST_REG}};
      bitcnt <= 4'h0;
      {data_complete_flag, address_or_stop_flag, cause, dir, rxack, acknowledge_action} <= 6'h00;
      {irq, scl_oe, sda_oe, waitreq} <= 4'h1;
      rdata <= 32'h0;
    end else begin
      st <= next_st;
      ack_nx <= next_ack_nx;
      {shift, own, msk, imask} <=
          {next_shift, next_own, next_msk, next_imask};
      bitcnt <= next_bitcnt;
      {data_complete_flag, address_or_stop_flag, cause, dir, rxack, acknowledge_action} <=
          {next_dif, next_address_or_stop_flag, next_cause, next_dir, next_rxack, next_acknowledge_action};
      {irq, scl_oe, sda_oe, waitreq} <=
          {next_irq, next_scl_oe, next_sda_oe, next_waitreq};
      rdata <= next_rdata;
    end
  end
  // open-drain: only ever pulls low
  always_ff @(posedge clk) begin
    {scl_out, sda_out} <= 2'b00;
  end
  assign avs_readdata = rdata;
  assign avs_waitrequest = waitreq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic byte_done;
  assign byte_done = st == S_ADDR && scl_fall && bitcnt == BITS_PER_BYTE
                     && !stop_c && !start_c;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_match;
    byte_done && addr_match(shift[7:1], own, msk)
      |=> address_or_stop_flag && cause && st == S_HOLD && scl_oe;
  endproperty
  a_match: assert property (p_match) else $error("no match");
  property p_mask;
    byte_done && !msk[0] && ((shift[7:1] ^ own[7:1]) & ~msk[7:1]) == 7'h00
      |=> address_or_stop_flag;
  endproperty
  a_mask: assert property (p_mask) else $error("masked miss");
  property p_second;
    byte_done && msk[0] && shift[7:1] == msk[7:1] |=> address_or_stop_flag && cause;
  endproperty
  a_second: assert property (p_second) else $error("second miss");
  property p_gcall;
    byte_done && own[0] && shift[7:1] == 7'h00 |=> address_or_stop_flag && dir == $past(shift[0]);
  endproperty
  a_gcall: assert property (p_gcall) else $error("gc miss");
  property p_stop;
    stop_c |=> address_or_stop_flag && !cause && st == S_IDLE ##1 !scl_oe;
  endproperty
  a_stop: assert property (p_stop) else $error("stop flag");
  property p_hold;
    scl_oe |-> (data_complete_flag || address_or_stop_flag) && st == S_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("bad stretch");
  property p_wr_block;
    wr_data && (st == S_ADDR || st == S_RX || st == S_TX) && !scl_rise
      && !scl_fall |=> $stable(shift);
  endproperty
  a_wr_block: assert property (p_wr_block) else $error("write leak");
  property p_clear;
    (rd_data || wr_data) && !dif_set |=> !data_complete_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("dif stuck");
  property p_launch;
    st == S_HOLD && !stop_c && !start_c && (wr_data || (rd_data && !dir))
      |=> st != S_HOLD ##1 !scl_oe;
  endproperty
  a_launch: assert property (p_launch) else $error("no launch");
  property p_wait;
    (avs_read || avs_write) && waitreq |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer");

  c_addr: cover property (byte_done ##1 address_or_stop_flag);
  c_tx: cover property (st == S_TX ##[1:1000] st == S_RACK);
  c_rx: cover property (st == S_RX ##[1:1000] data_complete_flag);
  c_stop: cover property (stop_c ##1 irq);
endmodule : twi_slave_match
`default_nettype wire

// *** twi_pkg.sv ***
package twi_pkg;
  // register word indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h0a;
  localparam logic [5:0] IDX_STATUS = 6'h0b;
  localparam logic [5:0] IDX_OWN = 6'h0c;
  localparam logic [5:0] IDX_DATA = 6'h0d;
  localparam logic [5:0] IDX_MASK = 6'h0e;
  localparam logic [5:0] IDX_IRQ_MASK = 6'h10;
  // status layout
  localparam int ST_DIF = 7;
  localparam int ST_ADDRESS_OR_STOP_FLAG = 6;
  localparam int ST_HOLD = 5;
  localparam int ST_RXACK = 4;
  localparam int ST_DIR = 1;
  localparam int ST_CAUSE = 0;
  // control layout
  localparam int CT_ACKNOWLEDGE_ACTION = 2;
  localparam logic [1:0] CMD_COMPTRANS = 2'h2;
  localparam logic [1:0] CMD_RESPONSE = 2'h3;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_HOLD = 3'b010,
    S_ACK = 3'b011,
    S_RX = 3'b100,
    S_TX = 3'b101,
    S_RACK = 3'b110
  } twi_state_t;

  typedef enum logic [1:0] {
    AN_RX = 2'b00,
    AN_HOLD = 2'b01,
    AN_IDLE = 2'b10
  } ack_next_t;
endpackage : twi_pkg

// *** serial_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // ------------------------------------------------------------
  // line phases, 80 ns clock period
  // ------------------------------------------------------------
  // a stretch may start just as we release: re-check after the wait
  task automatic rise;
    scl_low = 1'b0;
    do begin
      wait (scl === 1'b1);
      #20;
    end while (scl !== 1'b1);
  endtask : rise

  task automatic put_bit(input logic b, output logic r);
    #10 sda_low = ~b;
    #30 rise();
    r = sda;
    #20 scl_low = 1'b1;
  endtask : put_bit

  task automatic start_cond;
    #10 sda_low = 1'b0;
    #30 rise();
    sda_low = 1'b1;
    #20 scl_low = 1'b1;
  endtask : start_cond

  task automatic stop_cond;
    #10 sda_low = 1'b1;
    #30 rise();
    sda_low = 1'b0;
    #40;
  endtask : stop_cond

  // msb first, ninth bit carries the acknowledge
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
    put_bit(ack_in, ack);
  endtask : xfer
endmodule : serial_master_model
`default_nettype wire

// *** twi_slave_address_match_data_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module twi_slave_address_match_data_tb_top;
  import twi_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, scl_out, scl_oe, sda_out, sda_oe;
  logic m_scl_low, m_sda_low, scl_line, sda_line;
  int n_fail = 0;
  int check_count = 0;

  always #5 clk = ~clk;
  // open-drain lines with pull-ups
  assign scl_line = ~((scl_oe & ~scl_out) | m_scl_low);
  assign sda_line = ~((sda_oe & ~sda_out) | m_sda_low);

  twi_slave_match dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .scl_in(scl_line), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe));

  serial_master_model m (.scl(scl_line), .sda(sda_line),
    .scl_low(m_scl_low), .sda_low(m_sda_low));

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [5:0] idx,
      input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) check(32'h1, 32'h0);
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] mk,
      input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    check(q & {24'h0, mk}, {24'h0, e});
  endtask : rd

  // skip cycles first so a level from a just-cleared flag is not taken
  task automatic wait_irq;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(32'(irq), 32'h1);
  endtask : wait_irq

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic test_reset;
    logic [5:0] idx [6] = '{IDX_OWN, IDX_DATA, IDX_MASK, IDX_STATUS,
      IDX_IRQ_MASK, 6'h0f};
    foreach (idx[i]) rd(idx[i], 8'hff, 8'h00);
    wr(6'h0f, 8'h5a);
    rd(6'h0f, 8'hff, 8'h00);
    avs_byteenable <= 4'h0;
    wr(IDX_OWN, 8'h77);
    avs_byteenable <= 4'h1;
    rd(IDX_OWN, 8'hff, 8'h00);
    wr(IDX_IRQ_MASK, 8'hc0);
  endtask : test_reset

  task automatic addr_case(input logic [24:0] c);
    logic [7:0] rx;
    logic ack;
    wr(IDX_OWN, c[24:17]);
    wr(IDX_MASK, c[16:9]);
    fork
      begin
        m.start_cond();
        m.xfer(c[8:1], 1'b1, rx, ack);
      end
      if (c[0]) begin
        wait_irq();
        rd(IDX_STATUS, 8'hff, {6'h18, c[1], 1'b1});
        wr(IDX_CTRL, {6'h0, CMD_COMPTRANS});
      end
    join
    check(32'(ack), 32'(!c[0]));
    m.stop_cond();
    wait_irq();
    rd(IDX_STATUS, 8'hc1, 8'h40);
    wr(IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    wr(IDX_IRQ_MASK, 8'hc0);
    wr(IDX_STATUS, 8'hc0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
  endtask : addr_case

  task automatic rx_case;
    logic [7:0] rx;
    logic ack;
    wr(IDX_OWN, 8'h54);
    wr(IDX_MASK, 8'h00);
    fork
      begin
        m.start_cond();
        m.xfer(8'h54, 1'b1, rx, ack);
      end
      begin
        wait_irq();
        wr(IDX_CTRL, {6'h0, CMD_RESPONSE});
        rd(IDX_STATUS, 8'he0, 8'h00);
      end
    join
    check(32'(ack), 32'h0);
    fork
      m.xfer(8'ha5, 1'b1, rx, ack);
      begin
        repeat (30) @(posedge clk);
        wr(IDX_DATA, 8'h3c);
        wait_irq();
        rd(IDX_STATUS, 8'he0, 8'ha0);
        rd(IDX_DATA, 8'hff, 8'ha5);
      end
    join
    check(32'(ack), 32'h0);
    wr(IDX_CTRL, 8'h04);
    fork
      m.xfer(8'h5a, 1'b1, rx, ack);
      begin
        wait_irq();
        rd(IDX_DATA, 8'hff, 8'h5a);
      end
    join
    check(32'(ack), 32'h1);
    m.stop_cond();
    wait_irq();
    wr(IDX_STATUS, 8'hc0);
  endtask : rx_case

  task automatic tx_case;
    logic [7:0] rx;
    logic ack;
    wr(IDX_CTRL, 8'h00);
    fork
      begin
        m.start_cond();
        m.xfer(8'h55, 1'b1, rx, ack);
        m.xfer(8'hff, 1'b1, rx, ack);
      end
      begin
        wait_irq();
        wr(IDX_CTRL, {6'h0, CMD_RESPONSE});
        wait_irq();
        rd(IDX_STATUS, 8'he0, 8'ha0);
        wr(IDX_DATA, 8'hc3);
        wait_irq();
        rd(IDX_STATUS, 8'hf0, 8'hb0);
        wr(IDX_CTRL, {6'h0, CMD_COMPTRANS});
      end
    join
    check({24'h0, rx}, 32'hc3);
    m.stop_cond();
    wait_irq();
    rd(IDX_STATUS, 8'hc1, 8'h40);
    wr(IDX_STATUS, 8'hc0);
  endtask : tx_case

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  // own, mask, address byte, expected match
  logic [24:0] cases [12] = '{
    {8'h54, 8'h00, 8'h54, 1'b1},
    {8'h54, 8'h00, 8'h56, 1'b0},
    {8'h54, 8'h00, 8'h55, 1'b1},
    {8'h54, 8'h04, 8'h50, 1'b1},
    {8'h54, 8'h04, 8'h44, 1'b0},
    {8'h54, 8'h0d, 8'h0c, 1'b1},
    {8'h54, 8'h0d, 8'h58, 1'b0},
    {8'h54, 8'h0d, 8'h54, 1'b1},
    {8'hf6, 8'h00, 8'hf6, 1'b1},
    {8'hf6, 8'h00, 8'hf4, 1'b0},
    {8'h55, 8'h00, 8'h00, 1'b1},
    {8'h54, 8'h00, 8'h00, 1'b0}};

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    test_reset();
    foreach (cases[i]) addr_case(cases[i]);
    rx_case();
    tx_case();
    complete_run();
  end

  initial begin
    #400000;
    n_fail++;
    complete_run();
  end
endmodule : twi_slave_address_match_data_tb_top
`default_nettype wire
